// File: rtl/session_regs_pkg.sv
// Constants, field layouts and carriers for one session's user block.
// Assumes one system clock shared with the offload core FIFOs.
package session_regs_pkg;

   // -------------------------------------------------------------
   // Address map
   // -------------------------------------------------------------
   localparam int ADDR_W = 15;
   localparam int OFS_W = 13;
   localparam logic [15:0] SESSION_STRIDE = 16'h2000;
   localparam int USER_AREA_BIT = 12;
   localparam logic [OFS_W-1:0] OFS_TRANSMIT_LENGTH = 13'h1000;
   localparam logic [OFS_W-1:0] OFS_USER_COMMAND = 13'h1004;
   localparam logic [OFS_W-1:0] OFS_USER_RESET = 13'h1008;
   localparam logic [OFS_W-1:0] OFS_FIFO_STATUS = 13'h100C;
   localparam logic [OFS_W-1:0] OFS_RECEIVED_LENGTH = 13'h1010;
   localparam logic [OFS_W-1:0] OFS_CONNECTION_INTERRUPT = 13'h1020;
   localparam logic [OFS_W-1:0] OFS_MAC_VERSION = 13'h1080;

   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int CMD_START_BIT = 0;
   localparam int CMD_VERIFY_BIT = 1;
   localparam int STS_BUSY_BIT = 0;
   localparam int STS_FAIL_BIT = 1;
   localparam int STS_CONN_BIT = 2;
   localparam int RST_USER_BIT = 0;
   localparam int RST_TIMER_BIT = 8;
   localparam int RST_LINK_BIT = 16;
   localparam int FF_LAST_LSB = 0;
   localparam int FF_LAST_W = 4;
   localparam int FF_CNT_LSB = 4;
   localparam int FF_CNT_W = 12;
   localparam int FF_FULL_BIT = 24;
   localparam int CONN_FLAG_BIT = 0;

   // -------------------------------------------------------------
   // Data layout
   // -------------------------------------------------------------
   localparam int WORD_W = 32;
   localparam int LANES = 4;
   localparam int LANE_SEL_W = 2;
   localparam logic [WORD_W-1:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [WORD_W-1:0] WORD_ONE = 32'h0000_0001;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b01,
      TX_RUN = 2'b10
   } tx_state_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic wr_en;
      logic [WORD_W-1:0] wr_data;
      logic rd_req;
   } reg_req_t;

   typedef struct packed {
      logic [FF_LAST_W-1:0] rx_fifo_last_read_count;
      logic [FF_CNT_W-1:0] rx_fifo_read_count;
      logic tx_fifo_full;
      logic rx_fifo_empty;
   } fifo_flags_t;

endpackage

// File: rtl/session_user_block.sv
// One session's user block: registers, pattern generator, pattern verifier.
// Assumes the offload core FIFOs and the register port share clk.
//
// Notes on behaviour
// - FIFO status: last-read count [3:0], read count [15:4], tx full [24].
// - Received length counts rx units; cleared whenever user command is written.
// - Any edge on connection-active sets the connection interrupt flag, bit 0.
// - Writing one to bit 0 clears it; live connection level reads at command bit 2.
// - MAC version register is read-only, returning the MAC core's version.
// - Four sessions repeat this map at 0x2000 strides; user area at +0x1000.
// - Writing zero to command bit 0 starts the generator: transmit-run rises.
// - While running, tx write enable is the inverse of tx FIFO full.
// - Tx data is incrementing 32-bit values from the transmitted-word counter.
// - Transmit-run drops after the unit written while the counter equals configured size minus one.
// - With verify enabled each rx word is compared; otherwise data is drained.
// - Any mismatch while verifying sets the verification-fail flag.
// - Rx read enable is the inverse of rx FIFO empty.
// - Rx read data is valid for comparison one clock after read enable.
// - The received-word counter advances on read enable delayed one clock.
// - Expected pattern comes from the received-word counter, aligned with data.
// - Register reads answer after one cycle; read-valid is read request ANDed with session hit, flopped.
module session_user_block
   import session_regs_pkg::*;
#(
   parameter logic [1:0] SESSION_ID = 2'h0,
   parameter int CNT_W = 32
) (
   input wire logic clk,
   input wire logic nrst,
   input wire reg_req_t reg_req,
   output logic [WORD_W-1:0] reg_rd_data,
   output logic register_read_valid,
   input wire fifo_flags_t fifo_flags,
   output logic tx_fifo_write_enable,
   output logic [LANES*WORD_W-1:0] tx_fifo_write_data,
   output logic rx_fifo_read_enable,
   input wire logic [LANES*WORD_W-1:0] rx_fifo_read_data,
   input wire logic connection_active,
   input wire logic timer_int,
   input wire logic link_up,
   input wire logic [WORD_W-1:0] mac_core_version
);

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   logic [ADDR_W-1:0] session_base;
   logic session_hit;
   logic user_hit;
   logic [OFS_W-1:0] ofs;
   logic wr_cmd;
   logic wr_len;
   logic wr_rst;
   logic wr_conn;

   assign session_base = ADDR_W'(SESSION_STRIDE * SESSION_ID);
   assign session_hit = (reg_req.addr[ADDR_W-1:OFS_W] == session_base[ADDR_W-1:OFS_W]);
   assign ofs = reg_req.addr[OFS_W-1:0];
   assign user_hit = session_hit && ofs[USER_AREA_BIT];
   assign wr_cmd = user_hit && reg_req.wr_en && (ofs == OFS_USER_COMMAND);
   assign wr_len = user_hit && reg_req.wr_en && (ofs == OFS_TRANSMIT_LENGTH);
   assign wr_rst = user_hit && reg_req.wr_en && (ofs == OFS_USER_RESET);
   assign wr_conn = user_hit && reg_req.wr_en && (ofs == OFS_CONNECTION_INTERRUPT);

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   logic user_rst;
   logic [CNT_W-1:0] configured_transmit_size;
   logic verify_enable;
   logic timer_flag;

   // Self-clearing pulse, so software never has to write it back
   always_ff @(posedge clk) begin
      if (!nrst) begin
         user_rst <= 1'b0;
      end else begin
         user_rst <= wr_rst && reg_req.wr_data[RST_USER_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         configured_transmit_size <= '0;
         verify_enable <= 1'b0;
      end else begin
         if (wr_len) begin
            configured_transmit_size <= CNT_W'(reg_req.wr_data);
         end
         if (wr_cmd) begin
            verify_enable <= reg_req.wr_data[CMD_VERIFY_BIT];
         end
      end
   end

   // Set wins over clear so a tick in the clearing cycle survives
   always_ff @(posedge clk) begin
      if (!nrst) begin
         timer_flag <= 1'b0;
      end else if (timer_int) begin
         timer_flag <= 1'b1;
      end else if (wr_rst && reg_req.wr_data[RST_TIMER_BIT]) begin
         timer_flag <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Connection edge interrupt
   // ----------------------------------------------------------------
   logic conn_q;
   logic conn_flag;
   logic conn_edge;

   assign conn_edge = connection_active ^ conn_q;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         conn_q <= 1'b0;
         conn_flag <= 1'b0;
      end else begin
         conn_q <= connection_active;
         if (conn_edge) begin
            conn_flag <= 1'b1;
         end else if (wr_conn && reg_req.wr_data[CONN_FLAG_BIT]) begin
            conn_flag <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Pattern generator
   // ----------------------------------------------------------------
   tx_state_t tx_state;
   logic [CNT_W-1:0] transmitted_word_counter;
   logic transmit_run_enable;
   logic tx_write;
   logic tx_last;

   assign transmit_run_enable = (tx_state == TX_RUN);
   assign tx_write = transmit_run_enable && !fifo_flags.tx_fifo_full;
   assign tx_last = (transmitted_word_counter == configured_transmit_size - CNT_W'(1));
   // Combinational on purpose: a flopped enable would overrun a full FIFO
   assign tx_fifo_write_enable = tx_write;

   always_ff @(posedge clk) begin
      if (!nrst || user_rst) begin
         tx_state <= TX_IDLE;
      end else begin
         case (tx_state)
            TX_IDLE: begin
               if (wr_cmd && !reg_req.wr_data[CMD_START_BIT]) begin
                  tx_state <= TX_RUN;
               end
            end
            TX_RUN: begin
               if (tx_write && tx_last) begin
                  tx_state <= TX_IDLE;
               end
            end
            default: tx_state <= TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst || user_rst) begin
         transmitted_word_counter <= '0;
      end else if (tx_state == TX_IDLE && wr_cmd && !reg_req.wr_data[CMD_START_BIT]) begin
         transmitted_word_counter <= '0;
      end else if (tx_write) begin
         transmitted_word_counter <= transmitted_word_counter + CNT_W'(1);
      end
   end

   // ----------------------------------------------------------------
   // Pattern verifier
   // ----------------------------------------------------------------
   logic rx_read_enable_delayed;
   logic [CNT_W-1:0] received_word_counter;
   logic [LANES*WORD_W-1:0] expected_pattern;
   logic verification_fail;
   logic mismatch;

   // Empty FIFO never sees a read; the core accepts reads at full rate
   assign rx_fifo_read_enable = !fifo_flags.rx_fifo_empty;

   // Each 128-bit unit carries four consecutive 32-bit values
   for (genvar i = 0; i < LANES; i++) begin : g_lane
      assign tx_fifo_write_data[i*WORD_W +: WORD_W] =
         {transmitted_word_counter[WORD_W-LANE_SEL_W-1:0], LANE_SEL_W'(i)};
      assign expected_pattern[i*WORD_W +: WORD_W] =
         {received_word_counter[WORD_W-LANE_SEL_W-1:0], LANE_SEL_W'(i)};
   end

   assign mismatch = rx_read_enable_delayed && (rx_fifo_read_data != expected_pattern);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         rx_read_enable_delayed <= 1'b0;
      end else begin
         rx_read_enable_delayed <= rx_fifo_read_enable;
      end
   end

   // Counter clear on a command write may drop a unit arriving that cycle
   always_ff @(posedge clk) begin
      if (!nrst || user_rst || wr_cmd) begin
         received_word_counter <= '0;
      end else if (rx_read_enable_delayed) begin
         received_word_counter <= received_word_counter + CNT_W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst || user_rst) begin
         verification_fail <= 1'b0;
      end else if (verify_enable && mismatch) begin
         verification_fail <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Register read
   // ----------------------------------------------------------------
   logic [WORD_W-1:0] next_rd_data;

   always_comb begin
      next_rd_data = WORD_ZERO;
      if (!user_hit) begin
         next_rd_data = WORD_ZERO;
      end else if (ofs == OFS_TRANSMIT_LENGTH) begin
         next_rd_data = WORD_W'(transmitted_word_counter);
      end else if (ofs == OFS_USER_COMMAND) begin
         next_rd_data[STS_BUSY_BIT] = transmit_run_enable;
         next_rd_data[STS_FAIL_BIT] = verification_fail;
         next_rd_data[STS_CONN_BIT] = connection_active;
      end else if (ofs == OFS_USER_RESET) begin
         next_rd_data[RST_TIMER_BIT] = timer_flag;
         next_rd_data[RST_LINK_BIT] = link_up;
      end else if (ofs == OFS_FIFO_STATUS) begin
         next_rd_data[FF_LAST_LSB +: FF_LAST_W] = fifo_flags.rx_fifo_last_read_count;
         next_rd_data[FF_CNT_LSB +: FF_CNT_W] = fifo_flags.rx_fifo_read_count;
         next_rd_data[FF_FULL_BIT] = fifo_flags.tx_fifo_full;
      end else if (ofs == OFS_RECEIVED_LENGTH) begin
         next_rd_data = WORD_W'(received_word_counter);
      end else if (ofs == OFS_CONNECTION_INTERRUPT) begin
         next_rd_data[CONN_FLAG_BIT] = conn_flag;
      end else if (ofs == OFS_MAC_VERSION) begin
         next_rd_data = mac_core_version;
      end else begin
         next_rd_data = WORD_ZERO;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         reg_rd_data <= WORD_ZERO;
         register_read_valid <= 1'b0;
      end else begin
         reg_rd_data <= next_rd_data;
         register_read_valid <= reg_req.rd_req && session_hit;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   tx_write_gate_a: assert property (tx_fifo_write_enable |->
      transmit_run_enable && !fifo_flags.tx_fifo_full)
      else $error("tx write while idle or full");
   rx_read_gate_a: assert property (
      rx_fifo_read_enable == !fifo_flags.rx_fifo_empty)
      else $error("rx read enable not inverse of empty");
   read_latency_a: assert property (reg_req.rd_req && session_hit |=>
      register_read_valid ##1 (register_read_valid == $past(reg_req.rd_req && session_hit)))
      else $error("read valid latency wrong");
   conn_edge_a: assert property (
      (connection_active != conn_q) |=> conn_flag)
      else $error("connection edge not latched");
   conn_clear_a: assert property (wr_conn && reg_req.wr_data[CONN_FLAG_BIT] &&
      !conn_edge |=> !conn_flag)
      else $error("connection flag not cleared");
   start_run_a: assert property (
      tx_state == TX_IDLE && wr_cmd && !reg_req.wr_data[CMD_START_BIT] && !user_rst |=>
      transmit_run_enable && transmitted_word_counter == '0)
      else $error("start did not raise run");
   tx_count_a: assert property (tx_write && !user_rst |=>
      transmitted_word_counter == $past(transmitted_word_counter) + CNT_W'(1))
      else $error("tx counter did not advance");
   tx_end_a: assert property (
      tx_write && tx_last |=> !transmit_run_enable)
      else $error("run did not drop at last word");
   rx_count_a: assert property (rx_read_enable_delayed && !wr_cmd && !user_rst |=>
      received_word_counter == $past(received_word_counter) + CNT_W'(1))
      else $error("rx counter did not advance");
   rxlen_clear_a: assert property (
      wr_cmd |=> received_word_counter == '0)
      else $error("received length not cleared");
   // A user reset the cycle after a mismatch may clear the flag legally
   fail_set_a: assert property (verify_enable && mismatch && !user_rst |=>
      verification_fail ##1 (verification_fail || $past(user_rst)))
      else $error("mismatch not flagged or not held");
   fail_hold_a: assert property (
      verification_fail && !user_rst |=> verification_fail)
      else $error("fail flag dropped without reset");
   no_verify_a: assert property (!verification_fail && !verify_enable && !user_rst |=>
      !verification_fail)
      else $error("fail set while verify disabled");
   user_reset_a: assert property (user_rst |=>
      !transmit_run_enable && !verification_fail
      && transmitted_word_counter == '0 && received_word_counter == '0)
      else $error("user reset left state behind");

   // Read data is checked one cycle on, against what the mux saw
   status_read_a: assert property (
      reg_req.rd_req && user_hit && ofs == OFS_FIFO_STATUS |=>
      reg_rd_data[FF_FULL_BIT] == $past(fifo_flags.tx_fifo_full)
      && reg_rd_data[FF_CNT_LSB +: FF_CNT_W] == $past(fifo_flags.rx_fifo_read_count)
      && reg_rd_data[FF_LAST_LSB +: FF_LAST_W] == $past(fifo_flags.rx_fifo_last_read_count))
      else $error("fifo status fields misplaced");
   version_read_a: assert property (
      reg_req.rd_req && user_hit && ofs == OFS_MAC_VERSION |=>
      reg_rd_data == $past(mac_core_version))
      else $error("mac version not returned");
   conn_live_a: assert property (
      reg_req.rd_req && user_hit && ofs == OFS_USER_COMMAND |=>
      reg_rd_data[STS_CONN_BIT] == $past(connection_active))
      else $error("live connection level not readable");
   unmapped_read_a: assert property (
      reg_req.rd_req && session_hit && !user_hit |=> reg_rd_data == WORD_ZERO)
      else $error("core area read not zero");

   // ----------------------------------------------------------------
   // Cover points
   // ----------------------------------------------------------------
   transfer_done_c: cover property (transmit_run_enable ##1 !transmit_run_enable);
   full_stall_c: cover property (transmit_run_enable && fifo_flags.tx_fifo_full [*3] ##1 tx_write);
   mismatch_c: cover property (verify_enable && mismatch);
   conn_edge_c: cover property (conn_edge ##1 wr_conn);

endmodule

// File: sim/offload_fifo_model.sv
// Far-side model of the offload core transmit and receive FIFOs.
// Assumes the bench steers stall, receive fill level and one bad unit.
module offload_fifo_model
   import session_regs_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic tx_fifo_write_enable,
   input wire logic [LANES*WORD_W-1:0] tx_fifo_write_data,
   input wire logic rx_fifo_read_enable,
   input wire logic tx_stall,
   input wire logic [15:0] rx_limit,
   input wire logic [15:0] bad_index,
   output fifo_flags_t fifo_flags,
   output logic [LANES*WORD_W-1:0] rx_fifo_read_data,
   output logic [15:0] tx_count,
   output logic [15:0] tx_err
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] rx_sent;

   // Unit index in the upper bits, lane number in the low two
   function automatic logic [LANES*WORD_W-1:0] patt(input logic [15:0] n);
      for (int i = 0; i < LANES; i++) patt[i*WORD_W +: WORD_W] = {14'h0, n, i[1:0]};
   endfunction

   always_comb begin
      fifo_flags.rx_fifo_last_read_count = 4'h5;
      fifo_flags.rx_fifo_read_count = 12'hABC;
      fifo_flags.tx_fifo_full = tx_stall;
      fifo_flags.rx_fifo_empty = (rx_sent >= rx_limit);
   end

   // Data one clock after the read; scrambled otherwise so stale data never matches
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rx_sent <= 16'h0;
         rx_fifo_read_data <= '0;
      end else if (rx_fifo_read_enable && !fifo_flags.rx_fifo_empty) begin
         rx_sent <= rx_sent + 16'h1;
         rx_fifo_read_data <= (rx_sent == bad_index) ? ~patt(rx_sent) : patt(rx_sent);
      end else begin
         rx_fifo_read_data <= ~rx_fifo_read_data;
      end
   end

   // Writes while full or out of sequence are errors
   always_ff @(posedge clk) begin
      if (!nrst) begin
         tx_count <= 16'h0;
         tx_err <= 16'h0;
      end else if (tx_fifo_write_enable) begin
         tx_count <= tx_count + 16'h1;
         if (tx_stall || tx_fifo_write_data !== patt(tx_count)) tx_err <= tx_err + 16'h1;
      end
   end
endmodule

// File: sim/session_user_block_tb.sv
// Bench for one session's user block: register tasks and scripted tests.
// Assumes the FIFO model stands on the far side; session 1 is placed.
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin bad_count++; \
   $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module session_user_block_tb
   import session_regs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [1:0] SID = 2'h1;
   localparam logic [WORD_W-1:0] MAC_VER = 32'h5A3C_0102;
   logic clk, nrst, register_read_valid, tx_fifo_write_enable, rx_fifo_read_enable;
   logic connection_active, link_up, tx_stall;
   reg_req_t reg_req;
   fifo_flags_t fifo_flags;
   logic [WORD_W-1:0] reg_rd_data;
   logic [LANES*WORD_W-1:0] tx_fifo_write_data, rx_fifo_read_data;
   logic [15:0] rx_limit, bad_index, tx_count, tx_err;
   int bad_count = 0;
   int checks = 0;
   int cycles = 0;

   session_user_block #(.SESSION_ID(SID), .CNT_W(32)) session_user_block_i (.clk(clk),
      .nrst(nrst), .reg_req(reg_req), .reg_rd_data(reg_rd_data),
      .register_read_valid(register_read_valid), .fifo_flags(fifo_flags),
      .tx_fifo_write_enable(tx_fifo_write_enable), .tx_fifo_write_data(tx_fifo_write_data),
      .rx_fifo_read_enable(rx_fifo_read_enable), .rx_fifo_read_data(rx_fifo_read_data),
      .connection_active(connection_active), .timer_int(1'b0), .link_up(link_up),
      .mac_core_version(MAC_VER));
   offload_fifo_model offload_fifo_model_i (.clk(clk), .nrst(nrst),
      .tx_fifo_write_enable(tx_fifo_write_enable), .tx_fifo_write_data(tx_fifo_write_data),
      .rx_fifo_read_enable(rx_fifo_read_enable), .tx_stall(tx_stall), .rx_limit(rx_limit),
      .bad_index(bad_index), .fifo_flags(fifo_flags), .rx_fifo_read_data(rx_fifo_read_data),
      .tx_count(tx_count), .tx_err(tx_err));

   // ---------------------------------------------------------
   // Register access
   // ---------------------------------------------------------
   function automatic logic [ADDR_W-1:0] ua(input logic [OFS_W-1:0] ofs);
      return {SID, ofs};
   endfunction
   task automatic wr(input logic [OFS_W-1:0] ofs, input logic [WORD_W-1:0] d);
      @(posedge clk);
      reg_req <= '{addr: ua(ofs), wr_en: 1'b1, wr_data: d, rd_req: 1'b0};
      @(posedge clk);
      reg_req.wr_en <= 1'b0;
   endtask
   // Takes the answer one step after the edge that raises read-valid
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [WORD_W-1:0] d, output logic v);
      @(posedge clk);
      reg_req <= '{addr: a, wr_en: 1'b0, wr_data: WORD_ZERO, rd_req: 1'b1};
      @(posedge clk);
      reg_req.rd_req <= 1'b0;
      #1;
      v = register_read_valid;
      d = reg_rd_data;
   endtask
   task automatic chk(input logic [OFS_W-1:0] ofs, input logic [WORD_W-1:0] ex);
      logic [WORD_W-1:0] d;
      logic v;
      rd(ua(ofs), d, v);
      `CHK("read valid", 1'b1, v)
      `CHK("read data", ex, d)
   endtask
   task automatic wait_idle();
      logic [WORD_W-1:0] d;
      logic v;
      d = WORD_ONE;
      for (int n = 0; n < 100 && d[STS_BUSY_BIT] !== 1'b0; n++) rd(ua(OFS_USER_COMMAND), d, v);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Whole script needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         wrap_up();
      end
   end

   // ---------------------------------------------------------
   // Test script
   // ---------------------------------------------------------
   initial begin
      logic [WORD_W-1:0] d;
      logic v;
      nrst = 1'b0;
      reg_req = '0;
      connection_active = 1'b0;
      link_up = 1'b1;
      tx_stall = 1'b1;
      rx_limit = 16'h0;
      bad_index = 16'hFFFF;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      chk(OFS_FIFO_STATUS, 32'h0100_ABC5);
      wr(OFS_MAC_VERSION, 32'hFFFF_FFFF);
      chk(OFS_MAC_VERSION, MAC_VER);
      chk(OFS_USER_RESET, 32'h0001_0000);
      wr(13'h1040, 32'hFFFF_FFFF);
      chk(13'h1040, WORD_ZERO);
      chk(13'h0004, WORD_ZERO);
      rd({2'h0, OFS_MAC_VERSION}, d, v);
      `CHK("foreign valid", 1'b0, v)
      // Both connection edges latch the flag
      @(posedge clk) connection_active <= 1'b1;
      chk(OFS_USER_COMMAND, 32'h0000_0004);
      chk(OFS_CONNECTION_INTERRUPT, WORD_ONE);
      wr(OFS_CONNECTION_INTERRUPT, WORD_ONE);
      chk(OFS_CONNECTION_INTERRUPT, WORD_ZERO);
      @(posedge clk) connection_active <= 1'b0;
      chk(OFS_CONNECTION_INTERRUPT, WORD_ONE);
      // Five units with full stalls in mid-run
      wr(OFS_TRANSMIT_LENGTH, 32'h0000_0005);
      wr(OFS_USER_COMMAND, WORD_ZERO);
      chk(OFS_USER_COMMAND, WORD_ONE);
      `CHK("stalled writes", 16'h0, tx_count)
      @(posedge clk) tx_stall <= 1'b0;
      repeat (2) @(posedge clk);
      tx_stall <= 1'b1;
      repeat (3) @(posedge clk);
      tx_stall <= 1'b0;
      wait_idle();
      `CHK("tx units", 16'h5, tx_count)
      `CHK("tx pattern errors", 16'h0, tx_err)
      // Verified receive, then one corrupted unit
      wr(OFS_USER_COMMAND, 32'h0000_0003);
      @(posedge clk) rx_limit <= 16'd6;
      #1;
      `CHK("rx read enable", 1'b1, rx_fifo_read_enable)
      repeat (10) @(posedge clk);
      `CHK("rx read enable", 1'b0, rx_fifo_read_enable)
      chk(OFS_RECEIVED_LENGTH, 32'h0000_0006);
      chk(OFS_USER_COMMAND, WORD_ZERO);
      @(posedge clk);
      bad_index <= 16'd7;
      rx_limit <= 16'd9;
      repeat (8) @(posedge clk);
      chk(OFS_RECEIVED_LENGTH, 32'h0000_0009);
      chk(OFS_USER_COMMAND, 32'h0000_0002);
      // Command write clears the length; only a reset clears the fail flag
      wr(OFS_USER_COMMAND, WORD_ONE);
      chk(OFS_RECEIVED_LENGTH, WORD_ZERO);
      chk(OFS_USER_COMMAND, 32'h0000_0002);
      wr(OFS_USER_RESET, WORD_ONE);
      chk(OFS_USER_COMMAND, WORD_ZERO);
      // Out-of-step data drained unverified leaves the flag clear
      @(posedge clk) rx_limit <= 16'd12;
      repeat (8) @(posedge clk);
      chk(OFS_RECEIVED_LENGTH, 32'h0000_0003);
      chk(OFS_USER_COMMAND, WORD_ZERO);
      wrap_up();
   end
endmodule
